// File: dbrc_pkg.sv
/*
 Shared constants for the bus and reset controller.
 Assumes one 20 MHz system clock.
*/
package dbrc_pkg;
   localparam int          DBRC_ADDR_W       = 12;
   localparam int          DBRC_DATA_W       = 16;
   localparam logic [11:0] DBRC_ADDR_RST     = 12'h000;
   localparam logic [11:0] DBRC_PC_RST       = 12'h000;
   localparam logic [15:0] DBRC_DATA_RST     = 16'h0000;
   localparam int          DBRC_RST_MIN_CYC  = 5;
   localparam int          DBRC_RUN_DELAY    = 1;
   localparam logic [1:0]  DBRC_KIND_MEM     = 2'h0;
   localparam logic [1:0]  DBRC_KIND_IORD    = 2'h1;
   localparam logic [1:0]  DBRC_KIND_WR      = 2'h2;
   // Bus cycle phases, one-hot
   typedef enum logic [3:0]
   {
      DBRC_ST_RESET = 4'h1,
      DBRC_ST_WAKE  = 4'h2,
      DBRC_ST_IDLE  = 4'h4,
      DBRC_ST_ACC   = 4'h8
   } dbrc_state_e;
endpackage : dbrc_pkg

// File: dbrc_core.sv
/*
 Reset synchroniser and external bus strobe sequencer.
 Assumes the core logic gives requests on clk_sys and accepts data on req_done.
*/
`timescale 1ns/1ps
`default_nettype none
module dbrc_core
   import dbrc_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst_n,
   input  wire logic                   reset_in_n,
   // Core side
   input  wire logic                   req_valid,
   input  wire logic [1:0]             req_kind,
   input  wire logic [DBRC_ADDR_W-1:0] req_addr,
   input  wire logic [DBRC_DATA_W-1:0] req_wdata,
   output      logic                   req_ready,
   output      logic                   req_done,
   output      logic [DBRC_DATA_W-1:0] req_rdata,
   output      logic                   run,
   output      logic [DBRC_ADDR_W-1:0] pc_value,
   // External bus
   output      logic                   system_clock_out,
   output      logic [DBRC_ADDR_W-1:0] address_lines,
   input  wire logic [DBRC_DATA_W-1:0] data_lines_in,
   output      logic [DBRC_DATA_W-1:0] data_lines_out,
   output      logic                   data_lines_oe,
   output      logic                   program_mem_strobe_n,
   output      logic                   io_read_strobe_n,
   output      logic                   write_strobe_n
);
   ////////////////////////////////////////////////////////////////////
   logic        rs_meta_reg;
   logic        rs_sync_reg;
   logic        take;
   logic [DBRC_ADDR_W-1:0] pc_next;
   dbrc_state_e state_reg;
   dbrc_state_e state_next;
   logic [1:0]  kind_reg;
   logic [DBRC_DATA_W-1:0] din_neg_reg;

   // two-stage sync; tolerates any edge timing
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rs_meta_reg <= 1'b0;
         rs_sync_reg <= 1'b0;
      end
      else
      begin
         rs_meta_reg <= reset_in_n;
         rs_sync_reg <= rs_meta_reg;
      end
   end

   // Request taken this edge; next program counter
   always_comb
   begin
      take    = rs_sync_reg && state_reg == DBRC_ST_IDLE && req_valid;
      pc_next = 12'(req_addr + 12'h001);
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         DBRC_ST_RESET:
            if (rs_sync_reg)
               state_next = DBRC_ST_WAKE;
         DBRC_ST_WAKE:
            state_next = DBRC_ST_IDLE;
         DBRC_ST_IDLE:
            if (req_valid)
               state_next = DBRC_ST_ACC;
         // one cycle per access, then high
         DBRC_ST_ACC:
            state_next = DBRC_ST_IDLE;
         default:
            state_next = DBRC_ST_RESET;
      endcase
      if (!rs_sync_reg)
         state_next = DBRC_ST_RESET;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         state_reg <= DBRC_ST_RESET;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         run <= 1'b0;
      else
         run <= (state_next == DBRC_ST_IDLE) || (state_next == DBRC_ST_ACC);
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         req_ready <= 1'b0;
      else
         req_ready <= (state_next == DBRC_ST_IDLE);
   end

   ////////////////////////////////////////////////////////////////////
   // Address and program counter
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         address_lines <= DBRC_ADDR_RST;
         pc_value      <= DBRC_PC_RST;
         kind_reg      <= DBRC_KIND_MEM;
      end
      else if (!rs_sync_reg)
      begin
         address_lines <= DBRC_ADDR_RST;
         pc_value      <= DBRC_PC_RST;
      end
      else if (state_reg == DBRC_ST_IDLE && req_valid)
      begin
         address_lines <= req_addr;
         kind_reg      <= req_kind;
         if (req_kind == DBRC_KIND_MEM)
            pc_value <= pc_next;
      end
   end

   // strobes high while reset pin seen low
   // strobes decoded from one kind, one cycle
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         program_mem_strobe_n <= 1'b1;
         io_read_strobe_n     <= 1'b1;
         write_strobe_n       <= 1'b1;
      end
      else
      begin
         program_mem_strobe_n <= !(rs_sync_reg && state_reg == DBRC_ST_IDLE && req_valid
                                   && req_kind == DBRC_KIND_MEM);
         io_read_strobe_n     <= !(rs_sync_reg && state_reg == DBRC_ST_IDLE && req_valid
                                   && req_kind == DBRC_KIND_IORD);
         write_strobe_n       <= !(rs_sync_reg && state_reg == DBRC_ST_IDLE && req_valid
                                   && req_kind == DBRC_KIND_WR);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         data_lines_oe  <= 1'b0;
         data_lines_out <= DBRC_DATA_RST;
      end
      else
      begin
         data_lines_oe <= take && req_kind == DBRC_KIND_WR;
         if (state_reg == DBRC_ST_IDLE && req_valid)
            data_lines_out <= req_wdata;
      end
   end

   // Clock reference held high; strobes align to clk_sys
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         system_clock_out <= 1'b1;
      else
         system_clock_out <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////
   // sample at clock falling edge; strobe still low
   always_ff @(negedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         din_neg_reg <= DBRC_DATA_RST;
      else
         din_neg_reg <= data_lines_in;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         req_done  <= 1'b0;
         req_rdata <= DBRC_DATA_RST;
      end
      else
      begin
         req_done <= rs_sync_reg && state_reg == DBRC_ST_ACC;
         if (state_reg == DBRC_ST_ACC && kind_reg != DBRC_KIND_WR)
            req_rdata <= din_neg_reg;
      end
   end
endmodule : dbrc_core
`default_nettype wire

// File: dbrc_sva.sv
/* Port checker for dbrc_core.
 Assumes bind onto dbrc_core and rst_n low at start. */
`timescale 1ns/1ps
`default_nettype none
module dbrc_sva
   import dbrc_pkg::*;
(
   // Clock, reset, core side, bus address and data
   input wire logic        clk_sys, rst_n, reset_in_n, req_valid, req_ready, req_done, run,
   input wire logic [1:0]  req_kind,
   input wire logic [11:0] req_addr, pc_value, address_lines,
   input wire logic [15:0] req_wdata, req_rdata, data_lines_in, data_lines_out,
   // Bus strobes and data output enable
   input wire logic        data_lines_oe, program_mem_strobe_n, io_read_strobe_n, write_strobe_n
);
   logic idle;
   assign idle = program_mem_strobe_n & io_read_strobe_n & write_strobe_n;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_reset_quiet: assert property (!reset_in_n [*4] |-> idle && !data_lines_oe)
      else $error("bus active in reset");
   a_reset_clear: assert property (!reset_in_n [*4] |-> address_lines == '0 && pc_value == '0)
      else $error("address not cleared");
   a_one_strobe: assert property ($countones({program_mem_strobe_n, io_read_strobe_n,
      write_strobe_n}) >= 2)
      else $error("two strobes low");
   a_pulse_once: assert property (!idle |=> idle)
      else $error("strobe longer than one cycle");
   a_addr_valid: assert property (req_valid && req_ready && $past(reset_in_n, 2)
      |=> !idle && address_lines == $past(req_addr))
      else $error("address not valid at strobe");
   a_read_capture: assert property (!idle && write_strobe_n && $past(reset_in_n, 2)
      |=> req_done && req_rdata == $past(data_lines_in))
      else $error("read data not captured");
   a_write_drive: assert property (req_valid && req_ready && req_kind == DBRC_KIND_WR
      && $past(reset_in_n, 2)
      |=> !write_strobe_n && data_lines_oe && data_lines_out == $past(req_wdata))
      else $error("write cycle wrong");
   a_wake_run: assert property ($rose(reset_in_n) |-> !run [*3] ##[1:3] run)
      else $error("run not resumed");
   a_sync_entry: assert property ($fell(reset_in_n) && run |=> run ##[1:3] !run)
      else $error("reset entry not synchronised");
endmodule : dbrc_sva
bind dbrc_core dbrc_sva u_sva (.*);
`default_nettype wire

// File: dbrc_ext_mem.sv
/* External memory and peripheral model.
 Assumes the strobes of dbrc_core. */
`timescale 1ns/1ps
`default_nettype none
module dbrc_ext_mem
(
   input wire logic        clk_sys, program_mem_strobe_n, io_read_strobe_n, write_strobe_n,
   input wire logic [11:0] address_lines,
   input wire logic [15:0] data_lines_out,
   output logic     [15:0] data_lines_in
);
   logic [15:0] mem [0:4095];
   logic [15:0] last_reg = 16'h0000;
   always_ff @(posedge clk_sys)
      if (!write_strobe_n)
         mem[address_lines] <= data_lines_out;
   always_comb
      if (!program_mem_strobe_n)
         data_lines_in = mem[address_lines];
      else if (!io_read_strobe_n)
         data_lines_in = {4'h5, address_lines};
      else
         data_lines_in = ~last_reg;
   always_ff @(posedge clk_sys)
      last_reg <= data_lines_in;
endmodule : dbrc_ext_mem
`default_nettype wire

// File: dsp_bus_reset_control_bench.sv
/* Self-checking bench for dbrc_core.
 Assumes dbrc_ext_mem on the bus. */
`timescale 1ns/1ps
`default_nettype none
module dsp_bus_reset_control_bench;
   import dbrc_pkg::*;
   logic clk_sys, rst_n, reset_in_n, req_valid, req_ready, req_done, run, system_clock_out;
   logic data_lines_oe, program_mem_strobe_n, io_read_strobe_n, write_strobe_n;
   logic [1:0] req_kind;
   logic [11:0] req_addr, pc_value, address_lines;
   logic [15:0] req_wdata, req_rdata, data_lines_in, data_lines_out;
   int failures, n_checks, i;
   typedef struct { logic [1:0] k; logic [11:0] a; logic [15:0] d; logic [2:0] s;
      logic [11:0] p; } dbrc_row_s;
   dbrc_row_s rows [5] = '{'{DBRC_KIND_WR, 12'h010, 16'h1234, 3'h6, 12'h000},
      '{DBRC_KIND_WR, 12'hfff, 16'hbeef, 3'h6, 12'h000},
      '{DBRC_KIND_MEM, 12'h010, 16'h1234, 3'h3, 12'h011},
      '{DBRC_KIND_MEM, 12'hfff, 16'hbeef, 3'h3, 12'h000},
      '{DBRC_KIND_IORD, 12'h3a5, 16'h53a5, 3'h5, 12'h000}};
   dbrc_core DUT (.*);
   dbrc_ext_mem u_mem (.*);
   task automatic final_report;
      if (failures == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report
   task automatic check(input logic ok);
      n_checks++;
      if (ok !== 1'b1)
      begin
         failures++;
         $display("unexpected value at %0t", $time);
      end
   endtask : check
   task automatic wait_ready;
      for (i = 0; i < 12 && req_ready !== 1'b1; i++)
         @(negedge clk_sys);
      if (i == 12)
      begin
         failures++;
         final_report();
      end
   endtask : wait_ready
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial
   begin
      {rst_n, reset_in_n, req_valid, req_kind, req_addr, req_wdata} = '0;
      failures = 0;
      n_checks = 0;
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (6) @(negedge clk_sys);
      reset_in_n = 1'b1;
      foreach (rows[r])
      begin
         wait_ready();
         {req_kind, req_addr, req_wdata} = {rows[r].k, rows[r].a, rows[r].d};
         req_valid = 1'b1;
         @(negedge clk_sys);
         req_valid = 1'b0;
         check(address_lines === rows[r].a);
         check({program_mem_strobe_n, io_read_strobe_n, write_strobe_n} === rows[r].s);
         check(data_lines_oe === (rows[r].k == DBRC_KIND_WR));
         if (rows[r].k == DBRC_KIND_WR)
            check(data_lines_out === rows[r].d);
         check(req_ready === 1'b0 && system_clock_out === 1'b1);
         @(negedge clk_sys);
         check(req_done === 1'b1 && pc_value === rows[r].p);
         check({program_mem_strobe_n, io_read_strobe_n, write_strobe_n} === 3'h7);
         if (rows[r].k != DBRC_KIND_WR)
            check(req_rdata === rows[r].d);
      end
      wait_ready();
      {req_kind, req_valid} = {DBRC_KIND_WR, 1'b1};
      @(negedge clk_sys);
      req_valid = 1'b0;
      reset_in_n = 1'b0;
      repeat (5) @(negedge clk_sys);
      check(address_lines === 12'h000 && pc_value === 12'h000 && run === 1'b0);
      check({program_mem_strobe_n, io_read_strobe_n, write_strobe_n, data_lines_oe} === 4'he);
      reset_in_n = 1'b1;
      for (i = 0; i < 8 && run !== 1'b1; i++)
         @(negedge clk_sys);
      check(i >= 3 && i <= 5);
      final_report();
   end
endmodule : dsp_bus_reset_control_bench
`default_nettype wire
